// >>> hdl/conv_clock_select_pkg.sv
// Constants, register map and carrier types of the conversion sequencer.
// Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
package conv_clock_select_pkg;
  localparam int ADR_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_INTCTL  = 8'h0B;
  localparam logic [7:0] IDX_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_RES_HI  = 8'h1E;
  localparam logic [7:0] IDX_CTL     = 8'h1F;
  localparam logic [7:0] IDX_PINDIR  = 8'h85;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_RES_LO  = 8'h9E;
  localparam logic [7:0] IDX_ANALOG_SELECT_REG   = 8'h9F;
  // Values after reset and implemented bits
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_PINDIR  = 8'h3F;
  localparam logic [7:0] RST_ANALOG_SELECT_REG   = 8'h0F;
  localparam logic [7:0] MASK_CTL    = 8'hCD;
  localparam logic [7:0] MASK_ANALOG_SELECT_REG  = 8'h7F;
  localparam logic [7:0] MASK_PINDIR = 8'h3F;
  localparam logic [7:0] MASK_FLAGS  = 8'hC9;
  // Field positions
  localparam int CTL_JUSTIFY = 7;
  localparam int CTL_REF     = 6;
  localparam int CTL_CHAN    = 2;
  localparam int CTL_GO      = 1;
  localparam int CTL_POWER   = 0;
  localparam int ANS_CLK     = 4;
  localparam int FLAG_DONE   = 6;
  localparam int INT_GLOBAL  = 7;
  localparam int INT_PERIPH  = 6;
  // Conversion timing in conversion-clock periods
  localparam logic [3:0] CONV_TADS  = 4'hB;
  localparam logic [1:0] ABORT_TADS = 2'h2;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } conv_clock_select_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } conv_clock_select_wb_rsp_t;

  typedef struct packed {
    logic       active;
    logic       track;
    logic       hold;
    logic [3:0] chan_onehot;
    logic       ref_ext;
    logic [9:0] sar_code;
  } conv_clock_select_ana_t;

  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_ACQ   = 4'h2,
    ST_CONV  = 4'h4,
    ST_ABORT = 4'h8
  } conv_clock_select_state_t;
endpackage

// >>> hdl/conv_clock_select_sequencer.sv
// Conversion sequencer of a 10-bit SAR converter with Wishbone registers.
// Assumes comparator result is synchronous to clk; the RC oscillator input is synchronized to clk in two flops.
// Behaviour
// - Four inputs share one sample-and-hold
// - Successive approximation into result register pair
// - Control bits 3:2 select the channel
// - Control bit 6 picks external reference
// - Conversion lasts exactly eleven periods of a divided clock, ten to eleven of the RC clock
// - Select bits 6:4 pick conversion clock
// - Writing go one starts a conversion
// - Done clears go, sets flag, interrupts
// - Abort by clearing go keeps old result
// - Two ticks wait after an abort; the divider is not restarted, so the wait lasts one to two periods
// - Acquisition restarts itself after abort wait
// - Control bit 7 selects justification
// - Analog select bits disable digital buffers
// - Direction bits tristate pin drivers
// - Codes 0..3 map to inputs 0..3
// - Justify one right, zero left
// - Power bit enables the converter
`timescale 1ns/1ps
`default_nettype none
module conv_clock_select_sequencer
  import conv_clock_select_pkg::*;
#(
  parameter int RES_W = 10
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // Wishbone slave
  input  wire conv_clock_select_pkg::conv_clock_select_wb_req_t wb_req,
  output      conv_clock_select_pkg::conv_clock_select_wb_rsp_t wb_rsp,
  // Analog front end
  input  wire logic                  cmp_above,
  input  wire logic                  rc_osc,
  output      conv_clock_select_pkg::conv_clock_select_ana_t    ana,
  // Pins and interrupt
  output      logic [5:0]            pin_oe,
  output      logic [3:0]            dig_in_en,
  output      logic                  irq
);
  import conv_clock_select_pkg::*;

  // Register layout and SAR width are fixed
  if (RES_W != 10) begin : g_bad_width
    $error("RES_W must be 10");
  end

  function automatic logic [9:0] sar_step(input logic [9:0] code, input logic [3:0] bitn,
                                          input logic keep);
    logic [9:0] mask;
    mask = 10'h001 << bitn;
    sar_step = keep ? code : (code & ~mask);
    if (bitn != 4'h0) begin
      sar_step = sar_step | (mask >> 1);
    end
  endfunction

  function automatic logic [6:0] div_limit(input logic [2:0] code);
    div_limit = 7'((7'h02 << {code[1:0], code[2]}) - 7'h01);
  endfunction

  conv_clock_select_state_t st;
  conv_clock_select_state_t next_st;
  logic [7:0]  ctl;
  logic        go;
  logic [7:0]  analog_select_reg;
  logic [7:0]  pindir;
  logic [7:0]  flags;
  logic [7:0]  enables;
  logic [7:0]  intctl;
  logic [9:0]  sar;
  logic [9:0]  result;
  logic [3:0]  tcnt;
  logic [1:0]  acnt;
  logic [6:0]  div_cnt;
  logic        rc_meta;
  logic        rc_sync;
  logic        rc_prev;
  logic        ack;
  logic [7:0]  rd_q;

  // Bus decode
  wire         req      = wb_req.cyc & wb_req.stb;
  wire [7:0]   idx      = wb_req.adr[9:2];
  wire         wr       = req & ack & wb_req.we & wb_req.sel[0];
  wire [7:0]   wd       = wb_req.dat[7:0];
  wire         wr_ctl   = wr & (idx == IDX_CTL);
  wire         go_set   = wr_ctl & wd[CTL_GO];
  wire         go_clr   = wr_ctl & ~wd[CTL_GO];
  wire         power    = ctl[CTL_POWER];
  wire [2:0]   clk_code = analog_select_reg[ANS_CLK+2:ANS_CLK];
  wire         rc_mode  = (clk_code[1:0] == 2'b11);
  wire         rc_edge  = rc_sync & ~rc_prev;
  wire         div_hit  = (div_cnt == div_limit(clk_code));
  wire         tick     = rc_mode ? rc_edge : div_hit;
  wire         in_conv  = (st == ST_CONV);
  wire [3:0]   bitn     = 4'(4'h9 - (tcnt - 4'h1));
  wire [9:0]   sar_next = sar_step(sar, bitn, cmp_above);
  wire         done     = in_conv & tick & (tcnt == 4'(CONV_TADS - 4'h1));
  wire         abort    = in_conv & go_clr & ~done;
  wire         abort_end = (st == ST_ABORT) & tick & (acnt == 2'(ABORT_TADS - 2'h1));
  wire         rjust    = ctl[CTL_JUSTIFY];
  wire [7:0]   res_hi   = rjust ? {6'h00, result[9:8]} : result[9:2];
  wire [7:0]   res_lo   = rjust ? result[7:0] : {result[1:0], 6'h00};
  wire [7:0]   rd_val   = (idx == IDX_INTCTL)  ? intctl :
                          (idx == IDX_FLAGS)   ? flags :
                          (idx == IDX_RES_HI)  ? res_hi :
                          (idx == IDX_CTL)     ? (ctl | {6'h00, go, 1'b0}) :
                          (idx == IDX_PINDIR)  ? pindir :
                          (idx == IDX_ENABLES) ? enables :
                          (idx == IDX_RES_LO)  ? res_lo :
                          (idx == IDX_ANALOG_SELECT_REG)   ? analog_select_reg : 8'h00;

  always_comb begin
    next_st = st;
    case (st)
      ST_OFF:   next_st = power ? ST_ACQ : ST_OFF;
      ST_ACQ:   next_st = !power ? ST_OFF : (go_set ? ST_CONV : ST_ACQ);
      ST_CONV:  next_st = !power ? ST_OFF : (done ? ST_ACQ : (abort ? ST_ABORT : ST_CONV));
      ST_ABORT: next_st = !power ? ST_OFF : (abort_end ? ST_ACQ : ST_ABORT);
      default:  next_st = ST_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_OFF;
    end else begin
      st <= next_st;
    end
  end

  // Bus answer: one wait state, unmapped reads return zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack  <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      ack  <= req & ~ack;
      rd_q <= rd_val;
    end
  end

  // Software registers; hardware set of the done flag beats a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl     <= RST_ZERO;
      analog_select_reg   <= RST_ANALOG_SELECT_REG;
      pindir  <= RST_PINDIR;
      enables <= RST_ZERO;
      intctl  <= RST_ZERO;
      flags   <= RST_ZERO;
    end else begin
      if (wr_ctl) ctl <= wd & MASK_CTL;
      if (wr && idx == IDX_ANALOG_SELECT_REG) analog_select_reg <= wd & MASK_ANALOG_SELECT_REG;
      if (wr && idx == IDX_PINDIR) pindir <= wd & MASK_PINDIR;
      if (wr && idx == IDX_ENABLES) enables <= wd & MASK_FLAGS;
      if (wr && idx == IDX_INTCTL) intctl <= wd;
      if (wr && idx == IDX_FLAGS) flags <= wd & MASK_FLAGS;
      if (done) flags[FLAG_DONE] <= 1'b1;
    end
  end

  // Go is only taken while acquiring, so a start with power-on is ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      go <= 1'b0;
    end else if (!power || done || go_clr) begin
      go <= 1'b0;
    end else if (st == ST_ACQ && go_set) begin
      go <= 1'b1;
    end
  end

  // Conversion-clock divider restarts at each start for a full first period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 7'h00;
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
      rc_prev <= 1'b0;
    end else begin
      div_cnt <= (div_hit || st == ST_OFF || st == ST_ACQ) ? 7'h00 : 7'(div_cnt + 7'h01);
      rc_meta <= rc_osc;
      rc_sync <= rc_meta;
      rc_prev <= rc_sync;
    end
  end

  // SAR: first period samples, then one bit per period, MSB first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tcnt   <= 4'h0;
      acnt   <= 2'h0;
      sar    <= 10'h000;
      result <= 10'h000;
    end else begin
      if (st == ST_ACQ) begin
        tcnt <= 4'h0;
        acnt <= 2'h0;
        sar  <= 10'h200;
      end else if (in_conv && tick) begin
        tcnt <= 4'(tcnt + 4'h1);
        if (tcnt != 4'h0) sar <= sar_next;
      end else if (st == ST_ABORT && tick) begin
        acnt <= 2'(acnt + 2'h1);
      end
      if (done) result <= sar_next;
    end
  end

  assign wb_rsp.ack       = ack;
  assign wb_rsp.dat       = {24'h000000, rd_q};
  assign ana.active       = (st != ST_OFF);
  assign ana.track        = (st == ST_ACQ);
  assign ana.hold         = in_conv & (tcnt != 4'h0);
  assign ana.chan_onehot  = 4'h1 << ctl[CTL_CHAN+1:CTL_CHAN];
  assign ana.ref_ext      = ctl[CTL_REF];
  assign ana.sar_code     = sar;
  assign pin_oe           = ~pindir[5:0];
  assign dig_in_en        = ~analog_select_reg[3:0];
  assign irq              = flags[FLAG_DONE] & enables[FLAG_DONE] & intctl[INT_PERIPH] & intctl[INT_GLOBAL];

  // Checking helpers
  logic [3:0] ticks_seen;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ticks_seen <= 4'h0;
    end else if (!in_conv) begin
      ticks_seen <= 4'h0;
    end else if (tick) begin
      ticks_seen <= 4'(ticks_seen + 4'h1);
    end
  end

  property p_done_flag;
    @(posedge clk) disable iff (!arst_n) done |=> flags[FLAG_DONE] && !go && st == ST_ACQ;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done did not set flag or clear go");

  property p_eleven;
    @(posedge clk) disable iff (!arst_n) done |-> ticks_seen == 4'hA;
  endproperty
  a_eleven: assert property (p_eleven) else $error("conversion length not eleven periods");

  property p_abort_keep;
    @(posedge clk) disable iff (!arst_n) abort |=> $stable(result) && st == ST_ABORT;
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort disturbed result");

  property p_abort_wait;
    @(posedge clk) disable iff (!arst_n) (st == ST_ABORT && tick && acnt == 2'h0 && power)
      |=> st == ST_ABORT;
  endproperty
  a_abort_wait: assert property (p_abort_wait) else $error("abort wait too short");

  property p_reacquire;
    @(posedge clk) disable iff (!arst_n) (abort_end && power) |=> st == ST_ACQ && ana.track;
  endproperty
  a_reacquire: assert property (p_reacquire) else $error("no acquisition after abort");

  property p_start;
    @(posedge clk) disable iff (!arst_n) (st == ST_ACQ && go_set && power) |=> go && in_conv;
  endproperty
  a_start: assert property (p_start) else $error("go did not start conversion");

  property p_justify;
    @(posedge clk) disable iff (!arst_n) rjust |-> res_hi[7:2] == 6'h00 && res_lo == result[7:0];
  endproperty
  a_justify: assert property (p_justify) else $error("right justification wrong");

  property p_power_off;
    @(posedge clk) disable iff (!arst_n) (!power && st != ST_OFF) |=> st == ST_OFF && !go;
  endproperty
  a_power_off: assert property (p_power_off) else $error("converter not shut off");

  property p_div2;
    @(posedge clk) disable iff (!arst_n) (in_conv && clk_code == 3'b000 && tick && !done)
      |=> !tick ##1 tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two spacing wrong");

  property p_channel;
    @(posedge clk) disable iff (!arst_n) ana.chan_onehot[ctl[CTL_CHAN+1:CTL_CHAN]]
      && $onehot(ana.chan_onehot);
  endproperty
  a_channel: assert property (p_channel) else $error("channel decode wrong");

  // A retry during the abort wait must not restart the converter
  property p_wait_refuses_go;
    @(posedge clk) disable iff (!arst_n) (st == ST_ABORT && go_set) |=> !go && !in_conv;
  endproperty
  a_wait_refuses_go: assert property (p_wait_refuses_go) else $error("go taken during abort wait");

  property p_off_quiet;
    @(posedge clk) disable iff (!arst_n) (st == ST_OFF) |-> !ana.track && !ana.hold && !go;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("converter busy while off");
endmodule
`default_nettype wire

// >>> sim/conv_clock_select_analog_model.sv
// Analog side of the sequencer: four input levels and the RC oscillator.
// Assumes the bench supplies the levels and the sequencer clock.
`timescale 1ns/1ps
`default_nettype none
module conv_clock_select_analog_model
  import conv_clock_select_pkg::*;
(
  // Clock
  input  wire logic               clk,
  // Front end
  input  wire conv_clock_select_pkg::conv_clock_select_ana_t ana,
  input  wire logic [39:0]        levels,
  output      logic               cmp_above,
  output      logic               rc_osc
);
  import conv_clock_select_pkg::*;
  logic [9:0] lvl;
  int         rc_cnt = 0;
  // Mux picks the level of the one selected input
  always_comb begin
    lvl = 10'h000;
    for (int i = 0; i < 4; i++)
      if (ana.chan_onehot[i]) lvl = levels[i*10 +: 10];
  end
  assign cmp_above = (lvl >= ana.sar_code);
  // Free-running RC, 2 us period keeps the period legal
  initial rc_osc = 1'b0;
  always @(posedge clk) begin
    rc_cnt <= (rc_cnt == 39) ? 0 : rc_cnt + 1;
    if (rc_cnt == 39) rc_osc <= ~rc_osc;
  end
endmodule
`default_nettype wire

// >>> sim/conv_clock_select_sequencer_bench.sv
// Self-checking bench of the conversion sequencer.
// Assumes the analog model in the same folder.
`timescale 1ns/1ps
`default_nettype none
module conv_clock_select_sequencer_bench;
  import conv_clock_select_pkg::*;
  logic         clk;
  logic         arst_n;
  conv_clock_select_wb_req_t req;
  conv_clock_select_wb_rsp_t rsp;
  conv_clock_select_ana_t    ana;
  logic         cmp_above, rc_osc, irq;
  logic [5:0]   pin_oe;
  logic [3:0]   dig_in_en;
  logic [39:0]  levels = {10'h2C5, 10'h3FF, 10'h155, 10'h001};
  int           mismatches = 0, cmp_count = 0, cyc_n = 0;
  logic [7:0]   q, hi, lo;

  conv_clock_select_sequencer conv_clock_select_sequencer_i (.clk(clk), .arst_n(arst_n), .wb_req(req), .wb_rsp(rsp), .cmp_above(cmp_above),
    .rc_osc(rc_osc), .ana(ana), .pin_oe(pin_oe), .dig_in_en(dig_in_en), .irq(irq));
  conv_clock_select_analog_model conv_clock_select_analog_model_i (.clk(clk), .ana(ana), .levels(levels), .cmp_above(cmp_above),
    .rc_osc(rc_osc));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d, output logic [7:0] rd);
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, {ix, 2'b00}, 4'hF, {24'h0, d}};
    do @(posedge clk); while (rsp.ack !== 1'b1);
    rd = rsp.dat[7:0];
    req <= '0;
  endtask

  task automatic t_reset;
    logic [7:0] ix[7] = '{IDX_INTCTL, IDX_FLAGS, IDX_CTL, IDX_PINDIR, IDX_ENABLES, IDX_ANALOG_SELECT_REG, 8'h40};
    logic [7:0] ex[7] = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h0F, 8'h00};
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, ix[i], 8'h00, q);
      chk("reset value", q, ex[i]);
    end
    chk("oe at reset", pin_oe, 6'h00);
    chk("dig at reset", dig_in_en, 4'h0);
  endtask

  task automatic t_pins;
    wb(1'b1, IDX_PINDIR, 8'h05, q);
    wb(1'b1, IDX_ANALOG_SELECT_REG, 8'h0A, q);
    wb(1'b1, IDX_RES_HI, 8'hFF, q);
    wb(1'b1, 8'h40, 8'hFF, q);
    chk("pin_oe", pin_oe, 6'h3A);
    chk("dig_in_en", dig_in_en, 4'h5);
    wb(1'b0, IDX_RES_HI, 8'h00, q);
    chk("result read-only", q, 8'h00);
    wb(1'b0, 8'h40, 8'h00, q);
    chk("unmapped", q, 8'h00);
  endtask

  // Go in the power-on write is dropped
  task automatic t_power;
    wb(1'b1, IDX_CTL, 8'h03, q);
    wb(1'b0, IDX_CTL, 8'h00, q);
    chk("go with power-on", q, 8'h01);
    chk("active", ana.active, 1'b1);
  endtask

  task automatic conv(input logic [7:0] ctl, input logic [2:0] code, input int div);
    int n;
    logic [9:0] v;
    v = levels[int'(ctl[3:2])*10 +: 10];
    wb(1'b1, IDX_ANALOG_SELECT_REG, {1'b0, code, 4'hF}, q);
    wb(1'b1, IDX_CTL, ctl, q);
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("irq", irq, 1'b1);
    if (div > 0) chk("duration", (n >= 11*div-1 && n <= 12*div+1), 1'b1);
    chk("channel", ana.chan_onehot, 4'h1 << ctl[3:2]);
    chk("reference", ana.ref_ext, ctl[6]);
    wb(1'b0, IDX_CTL, 8'h00, q);
    chk("go cleared", q, ctl & 8'hFD);
    wb(1'b0, IDX_FLAGS, 8'h00, q);
    chk("done flag", q, 8'h40);
    wb(1'b0, IDX_RES_HI, 8'h00, hi);
    wb(1'b0, IDX_RES_LO, 8'h00, lo);
    chk("result high", hi, ctl[7] ? {6'h00, v[9:8]} : v[9:2]);
    chk("result low", lo, ctl[7] ? v[7:0] : {v[1:0], 6'h00});
    wb(1'b1, IDX_FLAGS, 8'h00, q);
  endtask

  task automatic t_convs;
    logic [2:0] code[7] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011};
    int div[7] = '{2, 4, 8, 16, 32, 64, 0};
    wb(1'b1, IDX_INTCTL, 8'hC0, q);
    wb(1'b1, IDX_ENABLES, 8'h40, q);
    for (int i = 0; i < 7; i++)
      conv({i[0], i[1], 2'b00, i[1:0], 2'b11}, code[i], div[i]);
  endtask

  // Abort mid-conversion, retry refused during the wait
  task automatic t_abort;
    int n;
    wb(1'b1, IDX_ANALOG_SELECT_REG, 8'h6F, q);
    wb(1'b1, IDX_CTL, 8'h03, q);
    repeat (200) @(posedge clk);
    chk("held", ana.hold, 1'b1);
    wb(1'b1, IDX_CTL, 8'h01, q);
    wb(1'b1, IDX_CTL, 8'h03, q);
    wb(1'b0, IDX_CTL, 8'h00, q);
    chk("go refused in wait", q, 8'h01);
    n = 0;
    while (ana.track !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("reacquire", (ana.track === 1'b1 && n <= 3*64), 1'b1);
    wb(1'b0, IDX_RES_HI, 8'h00, q);
    chk("kept high", q, hi);
    wb(1'b0, IDX_FLAGS, 8'h00, q);
    chk("no flag", q, 8'h00);
    wb(1'b1, IDX_CTL, 8'h00, q);
    wb(1'b0, IDX_CTL, 8'h00, q);
    chk("inactive", ana.active, 1'b0);
  endtask

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    arst_n = 1'b0;
    req = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_pins();
    t_power();
    t_convs();
    t_abort();
    conclude();
  end
endmodule
`default_nettype wire
